// *** hsm_cfg.svh ***
// Constants shared by both ends of the sensor message link.
// Assumes a 200 MHz system clock on both sides.
`ifndef HSM_CFG_SVH
`define HSM_CFG_SVH

// ==========================================================
// Sizes
`define HSM_MSG_MAX 6'h20
`define HSM_CNT_W 6
`define HSM_ADR_W 5

// ==========================================================
// Timing
`define HSM_SYS_MHZ 200
`define HSM_TCLK_NS 333
`define HSM_SCK_HALF ((`HSM_TCLK_NS * `HSM_SYS_MHZ + 1999) / 2000)
`define HSM_IDLE_US 50
`define HSM_IDLE_CYC (`HSM_IDLE_US * `HSM_SYS_MHZ)
`define HSM_INTD_US 500
`define HSM_INTD_CYC (`HSM_INTD_US * `HSM_SYS_MHZ)
`define HSM_RSTO_US 10
`define HSM_RSTO_CYC (`HSM_RSTO_US * `HSM_SYS_MHZ)

// ==========================================================
// Message classes and subclasses
`define HSM_CLS_MOUSE 8'h02
`define HSM_CLS_RSP 8'h05
`define HSM_CLS_DAT 8'h06
`define HSM_CLS_REQ 8'h07
`define HSM_CLS_FUSED 8'h26
`define HSM_SUB_FRS_WR 8'h06
`define HSM_SUB_FRS_DATA 8'h07
`define HSM_SUB_FRS_RD 8'h08
`define HSM_SUB_PROD_ID 8'h09
`define HSM_SUB_ACTIVITY 8'h12
`define HSM_SUB_MODE 8'h14
`define HSM_SUB_PERIOD 8'h16
`define HSM_SUB_BUTTON 8'h17
`define HSM_SUB_FW_STAT 8'h43
`define HSM_SUB_FW_CMD 8'h47
`define HSM_SUB_FW_DATA 8'h49

`endif

// *** hsm_pkg.sv ***
// Types shared by both ends of the sensor message link.
// Constants live in hsm_cfg.svh; the message decode helpers use them.
`include "hsm_cfg.svh"
package hsm_pkg;

  // Kind of request received from the host
  typedef enum logic [3:0] {
    HSM_K_NONE, HSM_K_PROD_ID, HSM_K_MODE, HSM_K_PERIOD, HSM_K_BUTTON,
    HSM_K_FRS_WR, HSM_K_FRS_DATA, HSM_K_FRS_RD, HSM_K_FW_STAT,
    HSM_K_FW_CMD, HSM_K_FW_DATA, HSM_K_OTHER
  } hsm_kind_t;

  // Host sequencer, Gray coded along the usual path
  typedef enum logic [2:0] {
    HSM_H_IDLE = 3'h0,
    HSM_H_SEL = 3'h1,
    HSM_H_HDR = 3'h3,
    HSM_H_WLEN = 3'h2,
    HSM_H_BODY = 3'h6,
    HSM_H_GAP = 3'h4
  } hsm_hst_t;

  // Maps a received class and subclass to a request kind
  function automatic hsm_kind_t decode(input logic [7:0] c,
                                       input logic [7:0] s);
    decode = HSM_K_OTHER;
    if (c == `HSM_CLS_REQ) begin
      case (s)
        `HSM_SUB_PROD_ID: decode = HSM_K_PROD_ID;
        `HSM_SUB_MODE: decode = HSM_K_MODE;
        `HSM_SUB_PERIOD: decode = HSM_K_PERIOD;
        `HSM_SUB_BUTTON: decode = HSM_K_BUTTON;
        `HSM_SUB_FRS_WR: decode = HSM_K_FRS_WR;
        `HSM_SUB_FRS_DATA: decode = HSM_K_FRS_DATA;
        `HSM_SUB_FRS_RD: decode = HSM_K_FRS_RD;
        `HSM_SUB_FW_STAT: decode = HSM_K_FW_STAT;
        `HSM_SUB_FW_CMD: decode = HSM_K_FW_CMD;
        `HSM_SUB_FW_DATA: decode = HSM_K_FW_DATA;
        default: decode = HSM_K_OTHER;
      endcase
    end
  endfunction

  // Only class and subclass pairs the module may send pass
  function automatic logic tx_legal(input logic [7:0] c,
                                    input logic [7:0] s);
    case (c)
      `HSM_CLS_RSP: tx_legal = (s == `HSM_SUB_FRS_WR) ||
                               (s == `HSM_SUB_MODE) ||
                               (s == `HSM_SUB_PERIOD) ||
                               (s == `HSM_SUB_FW_STAT);
      `HSM_CLS_DAT: tx_legal = (s == `HSM_SUB_FRS_RD) ||
                               (s == `HSM_SUB_PROD_ID);
      `HSM_CLS_REQ: tx_legal = (s == `HSM_SUB_ACTIVITY);
      `HSM_CLS_MOUSE: tx_legal = 1'b1;
      `HSM_CLS_FUSED: tx_legal = 1'b1;
      default: tx_legal = 1'b0;
    endcase
  endfunction

endpackage

// *** hsm_link_if.sv ***
// Pins between the sensor module end and the host end.
// The bench drives sel_pin; open-drain and tri-state levels resolve here.
`timescale 1ns/1ps
interface hsm_link_if;
  logic sck;
  logic mosi;
  logic csn_n;
  logic miso_d;
  logic miso_oe;
  logic miso;
  logic attn_n;
  logic sel_pin;
  logic rst_oe_dev;
  logic rst_oe_host;
  logic rst_line_n;

  // ==========================================================
  // Wire resolution: undriven data and the reset line idle high
  assign miso = miso_oe ? miso_d : 1'b1;
  assign rst_line_n = ~(rst_oe_dev | rst_oe_host);

  modport dev (
    input sck, mosi, csn_n, sel_pin, rst_line_n,
    output miso_d, miso_oe, attn_n, rst_oe_dev
  );
  modport host (
    input miso, attn_n, rst_line_n,
    output sck, mosi, csn_n, rst_oe_host
  );
endinterface

// *** hsm_dev.sv ***
// Sensor module end of the message link: serial slave, attention line,
// reset line driver. Assumes sck stops high outside frames and that
// the host keeps the select gap before starting the next frame.
// Functional notes
// - Select pin high or floating means USB
// - Module is slave only; host masters
// - Drive reset low on resets; accept external
// - Host waits for module's first access
// - Mode 3: launch falling, sample rising
// - Select stays high 50 us between frames
// - Attention released within 500 us of length
// - Abort keeps attention high at most idle gap
// - Pending message asserts attention
// - Second byte carries message length
// - Host clocks the larger of both lengths
// - Host with nothing sends length zero
// - Host waits for attention before data
// - Attention released after length; host waits
// - Nothing to return means length zero
// - Accept configuration requests of class 7
// - Accept record store requests of class 7
// - Accept firmware update; status answer class 5
// - Responses use class 5, request subclass
// - Record read and identity data class 6
// - Activity messages class 7 subclass 12
// - Cursor class 2, fused class 26
`timescale 1ns/1ps
`include "hsm_cfg.svh"
module hsm_dev (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic brownout_in,
  input wire logic soft_reset_in,
  hsm_link_if.dev link,
  input wire logic tx_wr_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_commit_in,
  output logic tx_ready_out,
  output logic tx_reject_out,
  output logic rx_done_out,
  output logic [`HSM_CNT_W-1:0] rx_count_out,
  output hsm_pkg::hsm_kind_t rx_kind_out,
  input wire logic [`HSM_ADR_W-1:0] rx_rd_addr_in,
  output logic [7:0] rx_rd_byte_out,
  output logic spi_mode_out,
  output logic line_reset_out
);
  import hsm_pkg::*;

  // ==========================================================
  // Storage
  logic [7:0] tx_mem [`HSM_MSG_MAX];
  logic [7:0] rx_mem [`HSM_MSG_MAX];
  logic pend_q, pend_d;
  logic [`HSM_CNT_W-1:0] tx_len_q, tx_len_d;

  // ==========================================================
  // Link clock domain
  logic [2:0] bit_q, bit_d;
  logic [`HSM_CNT_W-1:0] byte_q, byte_d, idx;
  logic fresh_q;
  logic [7:0] sh_d;
  logic [6:0] part_q;
  logic len_q, len_d;
  logic miso_q, miso_d;
  logic byte_end;

  // Byte index restarts at every frame, count survives the frame end
  assign idx = fresh_q ? '0 : byte_q;
  assign byte_end = (bit_q == 3'h7) && (idx != `HSM_MSG_MAX);

  // Shift in on the rising edge, MSB first
  always_comb begin
    bit_d = bit_q + 3'h1;
    sh_d = {part_q, link.mosi};
    byte_d = byte_end ? idx + 6'h1 : idx;
    len_d = (byte_d >= 6'h2);
  end

  // Select high clears the bit position, so a frame may stop anywhere
  always_ff @(posedge link.sck or posedge link.csn_n) begin
    if (link.csn_n) begin
      bit_q <= 3'h0;
      fresh_q <= 1'b1;
      len_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
      fresh_q <= 1'b0;
      len_q <= len_d;
    end
  end

  // Data path of the link domain, no reset needed
  always_ff @(posedge link.sck) begin
    part_q <= sh_d[6:0];
    byte_q <= byte_d;
    if (byte_end) begin
      rx_mem[idx[`HSM_ADR_W-1:0]] <= sh_d;
    end
  end

  // Launch data on the falling edge; zeros when nothing is pending,
  // which makes the length byte read as zero
  always_comb begin
    miso_d = 1'b0;
    if (pend_q && (idx < tx_len_q)) begin
      miso_d = tx_mem[idx[`HSM_ADR_W-1:0]][3'h7 - bit_q];
    end
  end

  // Pending and the message are frozen while a frame runs, because
  // the host waits for attention before the first clock
  always_ff @(negedge link.sck or posedge link.csn_n) begin
    if (link.csn_n) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= miso_d;
    end
  end

  // ==========================================================
  // Pin synchronisers into the system domain
  logic csn_m, csn_s, len_m, len_s, sel_m, sel_s, rl_m, rl_s;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      {csn_m, csn_s, len_m, len_s} <= 4'hc;
      {sel_m, sel_s, rl_m, rl_s} <= 4'hc; // Line is held low in reset
    end else begin
      {csn_m, csn_s} <= {link.csn_n, csn_m};
      {len_m, len_s} <= {len_q, len_m};
      {sel_m, sel_s} <= {link.sel_pin, sel_m};
      {rl_m, rl_s} <= {link.rst_line_n, rl_m};
    end
  end

  // ==========================================================
  // Reset line driver
  logic [11:0] hold_q, hold_d;
  logic oe_q, oe_d;
  logic [2:0] oe_hist_q;
  logic ext_q, ext_d;

  // Hold the open-drain line low after any local reset source
  always_comb begin
    hold_d = (hold_q != 12'h0) ? hold_q - 12'h1 : hold_q;
    if (brownout_in || soft_reset_in) begin
      hold_d = 12'(`HSM_RSTO_CYC);
    end
    oe_d = (hold_d != 12'h0);
    // Own drive echoes through the synchroniser; mask it out
    ext_d = ~rl_s && (oe_hist_q == 3'h0) && ~oe_q;
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      hold_q <= 12'(`HSM_RSTO_CYC);
      oe_q <= 1'b1;
      oe_hist_q <= 3'h7;
      ext_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      oe_q <= oe_d;
      oe_hist_q <= {oe_hist_q[1:0], oe_q};
      ext_q <= ext_d;
    end
  end

  // ==========================================================
  // Message control in the system domain
  logic rst_all, spi_en, frame, frame_q, seen_q, seen_d;
  logic attn_q, attn_d, done_q, done_d, rej_q, rej_d, tx_we;
  logic [`HSM_CNT_W-1:0] cnt_q, cnt_d;
  hsm_kind_t kind_q, kind_d;
  logic [7:0] rd_q;

  // A low reset line, driven by anyone, resets the message state
  assign rst_all = sys_rst_in || ~rl_s;
  assign spi_en = ~sel_s;
  assign frame = spi_en && ~csn_s;
  assign tx_we = tx_wr_in && tx_ready_out && (tx_len_q != `HSM_MSG_MAX);

  always_comb begin
    pend_d = pend_q;
    tx_len_d = tx_we ? tx_len_q + 6'h1 : tx_len_q;
    seen_d = frame ? (seen_q || len_s) : 1'b0;
    done_d = 1'b0;
    rej_d = 1'b0;
    cnt_d = cnt_q;
    kind_d = kind_q;
    if (tx_commit_in && tx_ready_out) begin
      if ((tx_len_q >= 6'h2) && tx_legal(tx_mem[0], tx_mem[2])) begin
        pend_d = 1'b1;
      end else begin
        rej_d = 1'b1;
        tx_len_d = 6'h0;
      end
    end
    // Frame end: a frame cut before the length is an abort and the
    // message stays pending for the next try
    if (frame_q && ~frame && seen_q) begin
      pend_d = 1'b0;
      tx_len_d = 6'h0;
      done_d = 1'b1;
      cnt_d = byte_q;
      kind_d = decode(rx_mem[0], rx_mem[2]);
    end
    // Attention: asked by a pending message, answered to a select,
    // dropped once the length bytes have passed
    attn_d = 1'b1;
    if (spi_en) begin
      if (frame) begin
        attn_d = len_s;
      end else begin
        attn_d = ~pend_d;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_all) begin
      pend_q <= 1'b0;
      tx_len_q <= 6'h0;
      frame_q <= 1'b0;
      seen_q <= 1'b0;
      attn_q <= 1'b1;
      done_q <= 1'b0;
      rej_q <= 1'b0;
      cnt_q <= 6'h0;
      kind_q <= HSM_K_NONE;
    end else begin
      pend_q <= pend_d;
      tx_len_q <= tx_len_d;
      frame_q <= frame;
      seen_q <= seen_d;
      attn_q <= attn_d;
      done_q <= done_d;
      rej_q <= rej_d;
      cnt_q <= cnt_d;
      kind_q <= kind_d;
    end
  end

  // Message bytes and the read port; the receive store is stable
  // between frames because the link clock stands still then
  always_ff @(posedge sys_clk_in) begin
    if (tx_we) begin
      tx_mem[tx_len_q[`HSM_ADR_W-1:0]] <= tx_byte_in;
    end
    rd_q <= rx_mem[rx_rd_addr_in];
  end

  // ==========================================================
  // Outputs
  assign link.miso_d = miso_q;
  assign link.miso_oe = spi_en && ~link.csn_n;
  assign link.attn_n = attn_q;
  assign link.rst_oe_dev = oe_q;
  assign tx_ready_out = ~pend_q && ~frame && ~frame_q;
  assign tx_reject_out = rej_q;
  assign rx_done_out = done_q;
  assign rx_count_out = cnt_q;
  assign rx_kind_out = kind_q;
  assign rx_rd_byte_out = rd_q;
  assign spi_mode_out = spi_en;
  assign line_reset_out = ext_q;
endmodule

// *** hsm_host.sv ***
// Host end of the message link: serial master on the system clock.
// Divides its clock to make the link clock; expects the module end.
`timescale 1ns/1ps
`include "hsm_cfg.svh"
module hsm_host #(
  parameter int unsigned IDLE_CYC = `HSM_IDLE_CYC,
  parameter int unsigned INTD_CYC = `HSM_INTD_CYC
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  hsm_link_if.host link,
  input wire logic reset_req_in,
  input wire logic tx_wr_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_commit_in,
  output logic tx_ready_out,
  output logic done_out,
  output logic abort_out,
  output logic dev_ready_out,
  output logic busy_out,
  output logic [`HSM_CNT_W-1:0] rx_count_out,
  input wire logic [`HSM_ADR_W-1:0] rx_rd_addr_in,
  output logic [7:0] rx_rd_byte_out
);
  import hsm_pkg::*;

  // ==========================================================
  // State
  logic [7:0] tx_mem [`HSM_MSG_MAX];
  logic [7:0] rx_mem [`HSM_MSG_MAX];
  hsm_hst_t st_q, st_d;
  logic [5:0] div_q, div_d;
  logic [2:0] bit_q, bit_d;
  logic [`HSM_CNT_W-1:0] byte_q, byte_d, tot_q, tot_d, len_q, len_d;
  logic [`HSM_CNT_W-1:0] mine, theirs, big;
  logic [7:0] sh_q, sh_d, rd_q;
  logic [16:0] tim_q, tim_d;
  logic sck_q, sck_d, mosi_q, mosi_d, csn_q, csn_d, run, rx_we, tx_we;
  logic pend_q, pend_d, rdy_q, rdy_d, di_q, di_d, done_q, done_d;
  logic abort_q, abort_d, attn_m, attn_s, miso_m, miso_s, rl_m, rl_s;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      {attn_m, attn_s, miso_m, miso_s, rl_m, rl_s} <= 6'h3f;
    end else begin
      {attn_m, attn_s} <= {link.attn_n, attn_m};
      {miso_m, miso_s} <= {link.miso, miso_m};
      {rl_m, rl_s} <= {link.rst_line_n, rl_m};
    end
  end

  // ==========================================================
  // Sequencer and bit engine
  assign mine = pend_q ? tx_mem[1][5:0] : 6'h0;
  assign theirs = rx_mem[1][5:0];
  assign big = (mine > theirs) ? mine : theirs;
  assign tx_we = tx_wr_in && tx_ready_out && (len_q != `HSM_MSG_MAX);

  always_comb begin
    st_d = st_q;
    div_d = div_q;
    sck_d = sck_q;
    mosi_d = mosi_q;
    csn_d = csn_q;
    bit_d = bit_q;
    byte_d = byte_q;
    sh_d = sh_q;
    tot_d = tot_q;
    tim_d = tim_q + 17'h1;
    pend_d = pend_q || (tx_commit_in && tx_ready_out);
    len_d = tx_we ? len_q + 6'h1 : len_q;
    rdy_d = rdy_q && rl_s;
    di_d = di_q;
    done_d = 1'b0;
    abort_d = 1'b0;
    rx_we = 1'b0;
    run = ((st_q == HSM_H_HDR) && (byte_q != 6'h2)) ||
          ((st_q == HSM_H_BODY) && (byte_q != tot_q));
    // Clock idles high; launch on falling, sample on rising
    if (run) begin
      div_d = div_q + 6'h1;
      if (div_q == 6'(`HSM_SCK_HALF - 1)) begin
        div_d = 6'h0;
        sck_d = ~sck_q;
        if (sck_q) begin
          mosi_d = (pend_q && byte_q < len_q) ?
                   tx_mem[byte_q[4:0]][3'h7 - bit_q] : 1'b0;
        end else begin
          sh_d = {sh_q[6:0], miso_s};
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            rx_we = 1'b1;
            byte_d = byte_q + 6'h1;
          end
        end
      end
    end
    case (st_q)
      HSM_H_IDLE: begin
        if (~attn_s || (pend_q && rdy_q)) begin
          di_d = ~attn_s;
          csn_d = 1'b0;
          tim_d = 17'h0;
          byte_d = 6'h0;
          bit_d = 3'h0;
          div_d = 6'h0;
          st_d = HSM_H_SEL;
        end
      end
      HSM_H_SEL: begin
        if (~attn_s) begin
          st_d = HSM_H_HDR;
        end else if (tim_q == 17'(INTD_CYC - 1)) begin
          abort_d = 1'b1;
          csn_d = 1'b1;
          tim_d = 17'h0;
          st_d = HSM_H_GAP;
        end
      end
      HSM_H_HDR: begin
        if (~run) begin
          tim_d = 17'h0;
          st_d = HSM_H_WLEN;
        end
      end
      HSM_H_WLEN: begin
        if (attn_s) begin
          tot_d = (big > `HSM_MSG_MAX) ? `HSM_MSG_MAX :
                  (big < 6'h2) ? 6'h2 : big;
          st_d = HSM_H_BODY;
        end else if (tim_q == 17'(INTD_CYC - 1)) begin
          abort_d = 1'b1;
          csn_d = 1'b1;
          tim_d = 17'h0;
          st_d = HSM_H_GAP;
        end
      end
      HSM_H_BODY: begin
        if (~run) begin
          csn_d = 1'b1;
          done_d = 1'b1;
          pend_d = 1'b0;
          len_d = 6'h0;
          rdy_d = rdy_q || di_q;
          tim_d = 17'h0;
          st_d = HSM_H_GAP;
        end
      end
      HSM_H_GAP: begin
        if (tim_q == 17'(IDLE_CYC - 1)) begin
          st_d = HSM_H_IDLE;
        end
      end
      default: st_d = HSM_H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_q <= HSM_H_IDLE;
      div_q <= 6'h0;
      sck_q <= 1'b1;
      mosi_q <= 1'b0;
      csn_q <= 1'b1;
      bit_q <= 3'h0;
      byte_q <= 6'h0;
      sh_q <= 8'h0;
      tot_q <= 6'h0;
      tim_q <= 17'h0;
      pend_q <= 1'b0;
      len_q <= 6'h0;
      rdy_q <= 1'b0;
      di_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      sck_q <= sck_d;
      mosi_q <= mosi_d;
      csn_q <= csn_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      sh_q <= sh_d;
      tot_q <= tot_d;
      tim_q <= tim_d;
      pend_q <= pend_d;
      len_q <= len_d;
      rdy_q <= rdy_d;
      di_q <= di_d;
      done_q <= done_d;
      abort_q <= abort_d;
    end
  end

  // Message stores and read port
  always_ff @(posedge sys_clk_in) begin
    if (tx_we) begin
      tx_mem[len_q[4:0]] <= tx_byte_in;
    end
    if (rx_we) begin
      rx_mem[byte_q[4:0]] <= sh_d;
    end
    rd_q <= rx_mem[rx_rd_addr_in];
  end

  // ==========================================================
  // Outputs
  assign link.sck = sck_q;
  assign link.mosi = mosi_q;
  assign link.csn_n = csn_q;
  assign link.rst_oe_host = reset_req_in;
  assign tx_ready_out = ~pend_q && (st_q == HSM_H_IDLE);
  assign done_out = done_q;
  assign abort_out = abort_q;
  assign dev_ready_out = rdy_q;
  assign busy_out = (st_q != HSM_H_IDLE);
  assign rx_count_out = byte_q;
  assign rx_rd_byte_out = rd_q;
endmodule

// *** hsm_link_properties.sv ***
// Concurrent checks on the pins between the module end and the host end.
// Assumes both ends run on sys_clk_in and sck is a host register.
`timescale 1ns/1ps
`include "hsm_cfg.svh"
module hsm_link_properties #(
  parameter int unsigned IDLE_CYC = `HSM_IDLE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic sck,
  input wire logic mosi,
  input wire logic csn_n,
  input wire logic miso_oe,
  input wire logic attn_n,
  input wire logic sel_pin,
  input wire logic rst_oe_dev,
  input wire logic rst_line_n
);
  localparam int RSTO = `HSM_RSTO_CYC;
  logic sck_q;
  logic [4:0] rise_q, rise_d;
  int gap_q, gap_d, drv_q, drv_d;
  // ==========================================================
  // Helpers: clock rises in frame, select gap, reset drive length
  always_comb begin
    rise_d = rise_q;
    if (csn_n)
      rise_d = 5'h00;
    else if (sck && !sck_q && rise_q < 5'h11)
      rise_d = rise_q + 5'h01;  // Saturates past the length bytes
    gap_d = csn_n ? ((gap_q < IDLE_CYC) ? gap_q + 1 : gap_q) : 0;
    drv_d = rst_oe_dev ? drv_q + 1 : 0;
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sck_q <= 1'b1;
      rise_q <= 5'h00;
      gap_q <= IDLE_CYC;  // Reset counts as a long idle
      drv_q <= 0;
    end else begin
      sck_q <= sck;
      rise_q <= rise_d;
      gap_q <= gap_d;
      drv_q <= drv_d;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  data_out_gate_a: assert property (
    miso_oe |-> !csn_n && !sel_pin) else $error("data out while idle");
  usb_mode_quiet_a: assert property (
    sel_pin [*6] |-> attn_n) else $error("attention in usb mode");
  clock_idle_a: assert property (
    csn_n |-> sck) else $error("clock low outside frame");
  launch_edge_a: assert property (
    !csn_n && !$past(csn_n) && $changed(mosi) |-> !sck)
    else $error("data launched off falling edge");
  len_release_a: assert property (
    $rose(rise_q == 5'h10) |-> ##[1:6] attn_n)
    else $error("attention held after length");
  attn_first_a: assert property (
    $fell(sck) && rise_q < 5'h10 |-> !attn_n)
    else $error("clocked without attention");
  wait_release_a: assert property (
    $fell(sck) && rise_q >= 5'h10 |-> attn_n)
    else $error("body clocked before release");
  select_gap_a: assert property (
    $fell(csn_n) |-> gap_q >= IDLE_CYC) else $error("select gap short");
  reset_drive_a: assert property (
    $fell(rst_oe_dev) |-> drv_q >= RSTO - 1)
    else $error("reset drive short");
  ext_reset_a: assert property (
    !rst_line_n [*5] |-> attn_n) else $error("active during reset");
endmodule

// *** sensor_module_spi_message_port_tb.sv ***
// Bench joining both ends over the link interface, with random traffic.
// Assumes the designs in hsm_dev, hsm_host and hsm_link_if.
`timescale 1ns/1ps
`include "hsm_cfg.svh"
module sensor_module_spi_message_port_tb;
  import hsm_pkg::*;
  logic sys_clk_in = 0, sys_rst_in = 1;
  logic brownout_in = 0, soft_reset_in = 0, reset_req_in = 0;
  logic d_wr = 0, d_commit = 0, h_wr = 0, h_commit = 0;
  logic [7:0] d_byte = 0, h_byte = 0, shm, shs, bm0, bs0;
  logic [4:0] d_addr = 0, h_addr = 0;
  wire d_ready, d_rej, d_done, spi_mode, line_rst;
  wire h_ready, h_done, h_abort, h_devrdy, h_busy;
  wire [5:0] d_cnt, h_cnt;
  wire [7:0] d_rb, h_rb;
  hsm_kind_t d_kind;
  logic [7:0] msg [32];
  logic [3:0] seen = 0;  // Sticky pulses: host done, rx done, abort, reject
  wire [6:0] ev = {lk.rst_line_n, h_ready, d_ready, seen};
  int seed = 87, n_errors = 0, total_checks = 0, len, nb = 0, k;
  logic [7:0] subs [10] = '{8'h09, 8'h14, 8'h16, 8'h17, 8'h06, 8'h07,
    8'h08, 8'h43, 8'h47, 8'h49};
  hsm_kind_t kinds [10] = '{HSM_K_PROD_ID, HSM_K_MODE, HSM_K_PERIOD,
    HSM_K_BUTTON, HSM_K_FRS_WR, HSM_K_FRS_DATA, HSM_K_FRS_RD,
    HSM_K_FW_STAT, HSM_K_FW_CMD, HSM_K_FW_DATA};
  logic [7:0] dcls [9] = '{8'h07, 8'h05, 8'h05, 8'h05, 8'h05, 8'h06,
    8'h06, 8'h02, 8'h26};
  logic [7:0] dsub [9] = '{8'h12, 8'h06, 8'h14, 8'h16, 8'h43, 8'h08,
    8'h09, 8'h5a, 8'ha5};
  hsm_link_if lk ();
  hsm_dev i_hsm_dev (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .brownout_in(brownout_in), .soft_reset_in(soft_reset_in),
    .link(lk.dev), .tx_wr_in(d_wr), .tx_byte_in(d_byte),
    .tx_commit_in(d_commit), .tx_ready_out(d_ready),
    .tx_reject_out(d_rej), .rx_done_out(d_done), .rx_count_out(d_cnt),
    .rx_kind_out(d_kind), .rx_rd_addr_in(d_addr), .rx_rd_byte_out(d_rb),
    .spi_mode_out(spi_mode), .line_reset_out(line_rst));
  // Short gap and timeout keep the run brief
  hsm_host #(.IDLE_CYC(200), .INTD_CYC(400)) i_hsm_host (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .link(lk.host),
    .reset_req_in(reset_req_in), .tx_wr_in(h_wr), .tx_byte_in(h_byte),
    .tx_commit_in(h_commit), .tx_ready_out(h_ready), .done_out(h_done),
    .abort_out(h_abort), .dev_ready_out(h_devrdy), .busy_out(h_busy),
    .rx_count_out(h_cnt), .rx_rd_addr_in(h_addr), .rx_rd_byte_out(h_rb));
  hsm_link_properties #(.IDLE_CYC(200)) i_hsm_link_properties (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .sck(lk.sck),
    .mosi(lk.mosi), .csn_n(lk.csn_n), .miso_oe(lk.miso_oe),
    .attn_n(lk.attn_n), .sel_pin(lk.sel_pin),
    .rst_oe_dev(lk.rst_oe_dev), .rst_line_n(lk.rst_line_n));
  // ==========================================================
  // Clock, pulse capture and wire monitor
  always #2.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) seen <= seen | {d_rej, h_abort, d_done, h_done};
  // First byte of each line, sampled on the rising edge
  always @(posedge lk.sck) begin
    shm = {shm[6:0], lk.mosi};
    shs = {shs[6:0], lk.miso};
    nb++;
    if (nb == 8) begin
      bm0 = shm;
      bs0 = shs;
    end
  end
  always @(negedge lk.csn_n) nb = 0;
  // ==========================================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait; pulses are sticky so none is missed
  task automatic wait_ev(input int w);
    int i;
    for (i = 0; i < 30000 && ev[w] !== 1'b1; i++)
      @(posedge sys_clk_in);
    if (ev[w] !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: wait %0d timed out", $time, w);
      final_report();
    end
    #1;
    if (w < 4)
      seen[w] = 1'b0;
  endtask
  function automatic int msg_len(input int n);
    return 3 + {$random(seed)} % n;  // Header plus a short body
  endfunction
  task automatic mk(input logic [7:0] c, input logic [7:0] s, input int n);
    int i;
    len = n;
    for (i = 0; i < 32; i++)
      msg[i] = $random(seed);
    msg[0] = c;
    msg[1] = 8'(n);
    msg[2] = s;
  endtask
  // Loads the message into one end, then commits it
  task automatic send(input bit dev, input int n);
    int i;
    wait_ev(dev ? 4 : 5);
    for (i = 0; i <= n; i++) begin
      @(posedge sys_clk_in);
      #1;
      d_wr = dev && i < n;
      h_wr = !dev && i < n;
      d_commit = dev && i == n;
      h_commit = !dev && i == n;
      d_byte = msg[i % 32];
      h_byte = msg[i % 32];
    end
    @(posedge sys_clk_in);
    #1;
    d_commit = 0;
    h_commit = 0;
  endtask
  task automatic rd(input bit dev, input int a, input logic [7:0] exp);
    d_addr = 5'(a);
    h_addr = 5'(a);
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk(dev ? d_rb : h_rb, exp);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    lk.sel_pin = 0;
    repeat (4) @(posedge sys_clk_in);
    #1;
    sys_rst_in = 0;
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk(8'(lk.rst_line_n), 8'h00);
    chk(8'(line_rst), 8'h00);
    chk(8'(h_devrdy), 8'h00);
    chk(8'(spi_mode), 8'h01);
    wait_ev(6);
    mk(8'h33, 8'h00, 3);
    send(1, len);
    wait_ev(3);
    chk(8'(lk.attn_n), 8'h01);
    $display("Test reset and refusal done");
    // Module frames; the first is the module's own first access
    for (k = 0; k < 9; k++) begin
      mk(dcls[k], dsub[k], msg_len(4));
      send(1, len);
      wait_ev(0);
      chk(8'(h_cnt), 8'(len));
      chk(8'(h_busy), 8'h01);
      for (int i = 0; i < len; i++)
        rd(0, i, msg[i]);
      chk(bs0, msg[0]);
      chk(8'(h_devrdy), 8'h01);
    end
    $display("Test module messages done");
    seen = 0;
    for (k = 0; k < 10; k++) begin
      mk(8'h07, subs[k], msg_len(4));
      send(0, len);
      wait_ev(0);
      wait_ev(1);
      chk(8'(d_kind), 8'(kinds[k]));
      chk(8'(d_cnt), 8'(len));
      for (int i = 0; i < len; i++)
        rd(1, i, msg[i]);
      chk(bm0, 8'h07);
      rd(0, 1, 8'h00);
    end
    $display("Test host requests done");
    lk.sel_pin = 1;
    repeat (10) @(posedge sys_clk_in);
    chk(8'(spi_mode), 8'h00);
    mk(8'h07, 8'h09, 3);
    send(0, len);
    wait_ev(2);
    chk(8'(lk.attn_n), 8'h01);
    $display("Test usb strap done");
    for (k = 0; k < 2; k++) begin
      brownout_in = k == 0;
      soft_reset_in = k == 1;
      @(posedge sys_clk_in);
      #1;
      brownout_in = 0;
      soft_reset_in = 0;
      repeat (4) @(posedge sys_clk_in);
      chk(8'(lk.rst_line_n), 8'h00);
      chk(8'(line_rst), 8'h00);
      wait_ev(6);
    end
    reset_req_in = 1;
    repeat (6) @(posedge sys_clk_in);
    chk(8'(line_rst), 8'h01);
    #1;
    reset_req_in = 0;
    $display("Test reset line done");
    final_report();
  end
endmodule
